// *** common/cell_prot_pkg.sv ***
// Purpose: constants and types shared by the cell protection state controller
// Assumes: 250 MHz system clock; internal protection tick of about 4 kHz
// Notes:   delay times are in ms, tick counts are derived from them
// Function
// - both gates on only inside every window
// - normal state: monitor resistor on, load resistors off
// - overcharge held for its delay turns charge off
// - split release: leave overcharge below release, load low
// - load high: leave overcharge below detection level
// - above overcharge level: no discharge overcurrent detection
// - equal levels: leave only with load high, below
// - overdischarge held for its delay turns discharge off
// - overdischarge: load pull-up on, pull-down off
// - leave overdischarge at detect level if load negative
// - power-down option: sleep with load high, wake low
// - power-down option: load high keeps overdischarge state
// - charger with load mid: leave at release level
// - no power-down option: never sleep, release normally
// - overheat held for its delay turns both off
// - inhibit option: charge gate to load below level
// - after attach no discharge until charger appears
// - delays count ticks of a 4 kHz oscillator
// - discharge overcurrent held turns discharge off, load releases
// - charge overcurrent held turns charge off, load releases
// - overheat released by cool level, off in overdischarge
package cell_prot_pkg;

   localparam int unsigned CLK_FREQ_HZ  = 250_000_000;
   localparam int unsigned OSC_FREQ_HZ  = 4_000;
   localparam int unsigned TICK_CYCLES  = CLK_FREQ_HZ / OSC_FREQ_HZ;

   localparam int unsigned OVERCHARGE_DELAY_MS    = 1000;
   localparam int unsigned OVERDISCHARGE_DELAY_MS = 128;
   localparam int unsigned DISCH_OC_DELAY_MS      = 8;
   localparam int unsigned CHARGE_OC_DELAY_MS     = 8;
   localparam int unsigned OVERHEAT_DELAY_MS      = 1000;

   localparam int unsigned CNT_W   = 16;
   localparam int unsigned NUM_DLY = 5;

   localparam int unsigned IDX_OVC = 0;
   localparam int unsigned IDX_OVD = 1;
   localparam int unsigned IDX_DOC = 2;
   localparam int unsigned IDX_COC = 3;
   localparam int unsigned IDX_OHT = 4;

   localparam logic [CNT_W-1:0] DELAY_TICKS [NUM_DLY] = '{
      CNT_W'((OVERCHARGE_DELAY_MS * OSC_FREQ_HZ) / 1000),
      CNT_W'((OVERDISCHARGE_DELAY_MS * OSC_FREQ_HZ) / 1000),
      CNT_W'((DISCH_OC_DELAY_MS * OSC_FREQ_HZ) / 1000),
      CNT_W'((CHARGE_OC_DELAY_MS * OSC_FREQ_HZ) / 1000),
      CNT_W'((OVERHEAT_DELAY_MS * OSC_FREQ_HZ) / 1000)
   };

   localparam int unsigned NUM_CMP = 14;

   typedef enum logic [7:0] {
      ST_ATTACH    = 8'h01,
      ST_NORMAL    = 8'h02,
      ST_OVERCHG   = 8'h04,
      ST_OVERDIS   = 8'h08,
      ST_POWERDOWN = 8'h10,
      ST_DISCH_OC  = 8'h20,
      ST_CHARGE_OC = 8'h40,
      ST_OVERHEAT  = 8'h80
   } prot_state_t;

   localparam logic [7:0] STATE_RESET = 8'h01;

endpackage : cell_prot_pkg

// *** logic/cell_protection_state_controller.sv ***
// Purpose: protection state machine, delay counters and gate/resistor controls
// Assumes: comparator inputs are level signals synchronous to clk_sys_i
// Notes:   option straps are caught on the first edge after reset release
`timescale 1ns/1ps
module cell_protection_state_controller #(
   parameter int unsigned TICK_CYCLES = cell_prot_pkg::TICK_CYCLES
)
(
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   // option straps
   input  wire logic       opt_split_release_i,
   input  wire logic       opt_power_down_i,
   input  wire logic       opt_zero_inhibit_i,
   // cell voltage comparators
   input  wire logic       cell_above_ovc_i,
   input  wire logic       cell_below_ovc_rel_i,
   input  wire logic       cell_below_ovd_i,
   input  wire logic       cell_at_ovd_rel_i,
   input  wire logic       cell_below_inhibit_i,
   // current sense comparators
   input  wire logic       sense_ge_disch_oc_i,
   input  wire logic       sense_le_charge_oc_i,
   // load sense pin comparators
   input  wire logic       load_ge_0p35_i,
   input  wire logic       load_below_0_i,
   input  wire logic       load_ge_0p7_i,
   input  wire logic       load_le_oc_rel_i,
   // thermistor comparators
   input  wire logic       temp_ge_detect_i,
   input  wire logic       temp_below_release_i,
   // outputs
   output logic            charge_gate_on_o,
   output logic            charge_gate_to_load_o,
   output logic            discharge_gate_on_o,
   output logic            monitor_gnd_res_on_o,
   output logic            load_pullup_on_o,
   output logic            load_pulldown_on_o,
   output logic            power_down_o,
   output logic [7:0]      state_o
);

   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // oscillator tick divider

   logic [TW-1:0] div_reg;
   logic          tick_reg;

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else if (div_reg == TICK_LAST)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg  <= div_reg + TW'(1);
         tick_reg <= 1'b0;
      end
   end

   // option straps, caught once after reset release

   logic strap_done_reg;
   logic split_rel_reg;
   logic pd_opt_reg;
   logic inhibit_opt_reg;

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         strap_done_reg  <= 1'b0;
         split_rel_reg   <= 1'b0;
         pd_opt_reg      <= 1'b0;
         inhibit_opt_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg  <= 1'b1;
         split_rel_reg   <= opt_split_release_i;
         pd_opt_reg      <= opt_power_down_i;
         inhibit_opt_reg <= opt_zero_inhibit_i;
      end
   end

   // comparator sampling on the tick; state logic only ever sees these
   // registered copies, so a comparator edge between ticks cannot split a decision

   logic [cell_prot_pkg::NUM_CMP-1:0] cmp_reg;
   logic [cell_prot_pkg::NUM_CMP-1:0] cmp_next;

   assign cmp_next = {cell_above_ovc_i, cell_below_ovc_rel_i, cell_below_ovd_i,
                      cell_at_ovd_rel_i, cell_below_inhibit_i, sense_ge_disch_oc_i,
                      sense_le_charge_oc_i, load_ge_0p35_i, load_below_0_i,
                      load_ge_0p7_i, load_le_oc_rel_i, temp_ge_detect_i,
                      temp_below_release_i, 1'b0};

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cmp_reg <= '0;
      end
      else if (tick_reg)
      begin
         cmp_reg <= cmp_next;
      end
   end

   logic s_above_ovc;
   logic s_below_ovc_rel;
   logic s_below_ovd;
   logic s_at_ovd_rel;
   logic s_below_inh;
   logic s_disch_oc;
   logic s_charge_oc;
   logic s_load_0p35;
   logic s_load_neg;
   logic s_load_0p7;
   logic s_load_rel;
   logic s_temp_hot;
   logic s_temp_cool;

   assign s_above_ovc     = cmp_reg[13];
   assign s_below_ovc_rel = cmp_reg[12];
   assign s_below_ovd     = cmp_reg[11];
   assign s_at_ovd_rel    = cmp_reg[10];
   assign s_below_inh     = cmp_reg[9];
   assign s_disch_oc      = cmp_reg[8];
   assign s_charge_oc     = cmp_reg[7];
   assign s_load_0p35     = cmp_reg[6];
   assign s_load_neg      = cmp_reg[5];
   assign s_load_0p7      = cmp_reg[4];
   assign s_load_rel      = cmp_reg[3];
   assign s_temp_hot      = cmp_reg[2];
   assign s_temp_cool     = cmp_reg[1];

   cell_prot_pkg::prot_state_t state_reg;
   cell_prot_pkg::prot_state_t state_next;

   // detection conditions, each armed only in the states where it may act

   logic [cell_prot_pkg::NUM_DLY-1:0] dly_cond;
   logic [cell_prot_pkg::NUM_DLY-1:0] dly_done;
   logic                              in_normal;
   logic                              can_overheat;

   assign in_normal    = (state_reg == cell_prot_pkg::ST_NORMAL);
   assign can_overheat = (state_reg == cell_prot_pkg::ST_NORMAL)
                       || (state_reg == cell_prot_pkg::ST_OVERCHG)
                       || (state_reg == cell_prot_pkg::ST_CHARGE_OC);

   always_comb
   begin
      dly_cond = '0;
      dly_cond[cell_prot_pkg::IDX_OVC] = in_normal && s_above_ovc;
      dly_cond[cell_prot_pkg::IDX_OVD] = in_normal && s_below_ovd;
      // an overfull cell masks discharge overcurrent sensing
      dly_cond[cell_prot_pkg::IDX_DOC] = in_normal && s_disch_oc && !s_above_ovc;
      dly_cond[cell_prot_pkg::IDX_COC] = in_normal && s_charge_oc;
      dly_cond[cell_prot_pkg::IDX_OHT] = can_overheat && s_temp_hot;
   end

   // one saturating tick counter per detection

   logic [cell_prot_pkg::CNT_W-1:0] dly_cnt_reg [cell_prot_pkg::NUM_DLY];

   genvar gi;
   generate
      for (gi = 0; gi < cell_prot_pkg::NUM_DLY; gi++)
      begin : g_delay
         always_ff @(posedge clk_sys_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               dly_cnt_reg[gi] <= '0;
            end
            else if (!dly_cond[gi])
            begin
               dly_cnt_reg[gi] <= '0;
            end
            else if (tick_reg && (dly_cnt_reg[gi] != cell_prot_pkg::DELAY_TICKS[gi]))
            begin
               dly_cnt_reg[gi] <= dly_cnt_reg[gi] + cell_prot_pkg::CNT_W'(1);
            end
         end
         assign dly_done[gi] = dly_cond[gi]
                            && (dly_cnt_reg[gi] == cell_prot_pkg::DELAY_TICKS[gi]);
      end
   endgenerate

   // state transitions

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         cell_prot_pkg::ST_ATTACH:
         begin
            // a freshly attached cell waits for a charger before discharge
            if (s_load_neg)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         cell_prot_pkg::ST_NORMAL:
         begin
            // overheat and cell faults take priority over current faults
            if (dly_done[cell_prot_pkg::IDX_OHT])
            begin
               state_next = cell_prot_pkg::ST_OVERHEAT;
            end
            else if (dly_done[cell_prot_pkg::IDX_OVD])
            begin
               state_next = cell_prot_pkg::ST_OVERDIS;
            end
            else if (dly_done[cell_prot_pkg::IDX_OVC])
            begin
               state_next = cell_prot_pkg::ST_OVERCHG;
            end
            else if (dly_done[cell_prot_pkg::IDX_DOC])
            begin
               state_next = cell_prot_pkg::ST_DISCH_OC;
            end
            else if (dly_done[cell_prot_pkg::IDX_COC])
            begin
               state_next = cell_prot_pkg::ST_CHARGE_OC;
            end
         end
         cell_prot_pkg::ST_OVERCHG:
         begin
            if (dly_done[cell_prot_pkg::IDX_OHT])
            begin
               state_next = cell_prot_pkg::ST_OVERHEAT;
            end
            else if (s_load_0p35 && !s_above_ovc)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
            else if (split_rel_reg && !s_load_0p35 && s_below_ovc_rel)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         cell_prot_pkg::ST_OVERDIS:
         begin
            if (s_load_neg && !s_below_ovd)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
            else if (pd_opt_reg && s_load_0p7)
            begin
               // sleeping also holds off release at the release level
               state_next = cell_prot_pkg::ST_POWERDOWN;
            end
            else if (s_at_ovd_rel)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         cell_prot_pkg::ST_POWERDOWN:
         begin
            if (!s_load_0p7)
            begin
               state_next = cell_prot_pkg::ST_OVERDIS;
            end
         end
         cell_prot_pkg::ST_DISCH_OC:
         begin
            if (s_load_rel)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         cell_prot_pkg::ST_CHARGE_OC:
         begin
            if (dly_done[cell_prot_pkg::IDX_OHT])
            begin
               state_next = cell_prot_pkg::ST_OVERHEAT;
            end
            else if (s_load_0p35)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         cell_prot_pkg::ST_OVERHEAT:
         begin
            if (s_temp_cool)
            begin
               state_next = cell_prot_pkg::ST_NORMAL;
            end
         end
         default:
         begin
            state_next = cell_prot_pkg::ST_ATTACH;
         end
      endcase
   end

   // the state only moves on a tick, so transitions stay on the slow time base
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg <= cell_prot_pkg::prot_state_t'(cell_prot_pkg::STATE_RESET);
      end
      else if (tick_reg && strap_done_reg)
      begin
         state_reg <= state_next;
      end
   end

   // gate controls, registered from the state and the inhibit comparator

   logic inhibit_now;

   assign inhibit_now = inhibit_opt_reg && s_below_inh;

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         charge_gate_on_o      <= 1'b0;
         charge_gate_to_load_o <= 1'b0;
         discharge_gate_on_o   <= 1'b0;
      end
      else
      begin
         // both gates on together only in the normal state
         discharge_gate_on_o <= (state_reg == cell_prot_pkg::ST_NORMAL)
                             || (state_reg == cell_prot_pkg::ST_OVERCHG)
                             || (state_reg == cell_prot_pkg::ST_CHARGE_OC);
         charge_gate_on_o    <= !inhibit_now
                             && (state_reg != cell_prot_pkg::ST_OVERCHG)
                             && (state_reg != cell_prot_pkg::ST_CHARGE_OC)
                             && (state_reg != cell_prot_pkg::ST_OVERHEAT)
                             && (state_reg != cell_prot_pkg::ST_POWERDOWN);
         charge_gate_to_load_o <= inhibit_now;
      end
   end

   // internal resistor switches and sleep indication

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         monitor_gnd_res_on_o <= 1'b0;
         load_pullup_on_o     <= 1'b0;
         load_pulldown_on_o   <= 1'b0;
         power_down_o         <= 1'b0;
      end
      else
      begin
         monitor_gnd_res_on_o <= (state_reg == cell_prot_pkg::ST_NORMAL)
                              || ((state_reg == cell_prot_pkg::ST_OVERDIS)
                                  && s_load_neg);
         load_pullup_on_o     <= (state_reg == cell_prot_pkg::ST_OVERDIS)
                              || (state_reg == cell_prot_pkg::ST_POWERDOWN);
         load_pulldown_on_o   <= (state_reg == cell_prot_pkg::ST_DISCH_OC);
         power_down_o         <= (state_reg == cell_prot_pkg::ST_POWERDOWN);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_o <= 8'h00;
      end
      else
      begin
         state_o <= state_reg;
      end
   end

endmodule : cell_protection_state_controller

// *** testbench/cell_prot_asserts.sv ***
// Purpose: concurrent checks on the protection controller ports
// Assumes: state_o and the gate/resistor outputs come from one state register
// Notes:   delay checks count raw clocks, so a short delay counter is caught too
`timescale 1ns/1ps
module cell_prot_asserts #(
   parameter int unsigned TICK_CYCLES = 4
)
(
   input wire logic       clk_sys_i,
   input wire logic       rst_b_i,
   input wire logic       cell_above_ovc_i,
   input wire logic       cell_below_ovd_i,
   input wire logic       charge_gate_on_o,
   input wire logic       charge_gate_to_load_o,
   input wire logic       discharge_gate_on_o,
   input wire logic       monitor_gnd_res_on_o,
   input wire logic       load_pullup_on_o,
   input wire logic       load_pulldown_on_o,
   input wire logic       power_down_o,
   input wire logic [7:0] state_o
);
   int unsigned ovd_run;
   int unsigned ovc_run;
   // unbroken run lengths of the two cell comparators
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i) ovd_run <= 32'h0;
      else ovd_run <= cell_below_ovd_i ? ovd_run + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i) ovc_run <= 32'h0;
      else ovc_run <= cell_above_ovc_i ? ovc_run + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   gates_on_a: assert property (state_o == 8'h02 [*2] |->
      discharge_gate_on_o && (charge_gate_on_o || charge_gate_to_load_o))
      else $error("gates not both on in normal state");
   normal_res_a: assert property (state_o == 8'h02 [*2] |->
      monitor_gnd_res_on_o && !load_pullup_on_o && !load_pulldown_on_o)
      else $error("resistor set wrong in normal state");
   ovc_gate_a: assert property (state_o == 8'h04 [*2] |-> !charge_gate_on_o)
      else $error("charge gate on in overcharge");
   ovc_delay_a: assert property (state_o == 8'h04 && $past(state_o) == 8'h02 |->
      ovc_run >= (cell_prot_pkg::DELAY_TICKS[cell_prot_pkg::IDX_OVC] - 1) * TICK_CYCLES)
      else $error("overcharge entered before its delay");
   ovd_delay_a: assert property (state_o == 8'h08 && $past(state_o) == 8'h02 |->
      ovd_run >= (cell_prot_pkg::DELAY_TICKS[cell_prot_pkg::IDX_OVD] - 1) * TICK_CYCLES)
      else $error("overdischarge entered before its delay");
   ovd_res_a: assert property (state_o == 8'h08 [*2] |->
      load_pullup_on_o && !load_pulldown_on_o && !discharge_gate_on_o)
      else $error("overdischarge outputs wrong");
   pd_entry_a: assert property ($rose(power_down_o) |-> $past(state_o) == 8'h08)
      else $error("power-down not entered from overdischarge");
   pd_exit_a: assert property ($fell(power_down_o) |-> state_o == 8'h08)
      else $error("power-down left to wrong state");
   heat_off_a: assert property (state_o == 8'h80 [*2] |->
      !charge_gate_on_o && !discharge_gate_on_o)
      else $error("gate on in overheat");
   inhibit_a: assert property (charge_gate_to_load_o |-> !charge_gate_on_o)
      else $error("charge gate on while tied to load");
   doc_out_a: assert property (state_o == 8'h20 [*2] |->
      !discharge_gate_on_o && load_pulldown_on_o && !load_pullup_on_o)
      else $error("discharge overcurrent outputs wrong");
   coc_gate_a: assert property (state_o == 8'h40 [*2] |-> !charge_gate_on_o)
      else $error("charge gate on in charge overcurrent");
endmodule : cell_prot_asserts
bind cell_protection_state_controller cell_prot_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk_sys_i, .rst_b_i, .cell_above_ovc_i, .cell_below_ovd_i, .charge_gate_on_o,
   .charge_gate_to_load_o, .discharge_gate_on_o, .monitor_gnd_res_on_o,
   .load_pullup_on_o, .load_pulldown_on_o, .power_down_o, .state_o);

// *** testbench/pack_side_model.sv ***
// Purpose: far side of the guard: cell, charger, load and thermistor as comparator levels
// Assumes: level codes are monotone, so no two comparator outputs contradict each other
// Notes:   cell 0 inhibit, 1 overdischarged, 2 hysteresis, 3 normal, 4 near full, 5 over
`timescale 1ns/1ps
module pack_side_model
(
   input  wire logic [2:0] cell_lvl_i,
   input  wire logic [2:0] load_lvl_i,
   input  wire logic [1:0] temp_lvl_i,
   output logic            above_ovc_o,
   output logic            below_ovc_rel_o,
   output logic            below_ovd_o,
   output logic            at_ovd_rel_o,
   output logic            below_inh_o,
   output logic            ge_0p35_o,
   output logic            below_0_o,
   output logic            ge_0p7_o,
   output logic            le_oc_rel_o,
   output logic            hot_o,
   output logic            cool_o
);
   assign above_ovc_o     = cell_lvl_i == 3'h5;
   assign below_ovc_rel_o = cell_lvl_i < 3'h4;
   assign below_ovd_o     = cell_lvl_i < 3'h2;
   assign at_ovd_rel_o    = cell_lvl_i > 3'h2;
   assign below_inh_o     = cell_lvl_i == 3'h0;
   // load 0 charger below 0 V, 1 near 0 V, 2 mid, 3 above 0.7 V, 4 at supply
   assign below_0_o       = load_lvl_i == 3'h0;
   assign ge_0p35_o       = load_lvl_i > 3'h1;
   assign ge_0p7_o        = load_lvl_i > 3'h2;
   assign le_oc_rel_o     = load_lvl_i < 3'h4;
   // temp 0 cool, 1 inside hysteresis, 2 hot
   assign hot_o           = temp_lvl_i == 2'h2;
   assign cool_o          = temp_lvl_i == 2'h0;
endmodule : pack_side_model

// *** testbench/test_cell_protection_state_controller.sv ***
// Purpose: directed scenarios for the protection state controller
// Assumes: short tick of 4 clocks; package delay counts kept as they are
// Notes:   straps are caught once, so each option set gets its own reset
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_cell_protection_state_controller;
   localparam int TK  = 4;
   localparam int OVC = cell_prot_pkg::DELAY_TICKS[cell_prot_pkg::IDX_OVC];
   localparam int OVD = cell_prot_pkg::DELAY_TICKS[cell_prot_pkg::IDX_OVD];
   localparam int OHT = cell_prot_pkg::DELAY_TICKS[cell_prot_pkg::IDX_OHT];
   logic clk_sys_i, rst_b_i, opt_split_release_i, opt_power_down_i, opt_zero_inhibit_i;
   logic cell_above_ovc_i, cell_below_ovc_rel_i, cell_below_ovd_i, cell_at_ovd_rel_i;
   logic cell_below_inhibit_i, sense_ge_disch_oc_i, sense_le_charge_oc_i, load_ge_0p35_i;
   logic load_below_0_i, load_ge_0p7_i, load_le_oc_rel_i, temp_ge_detect_i;
   logic temp_below_release_i, charge_gate_on_o, charge_gate_to_load_o, discharge_gate_on_o;
   logic monitor_gnd_res_on_o, load_pullup_on_o, load_pulldown_on_o, power_down_o;
   logic [7:0] state_o;
   logic [2:0] cell_lvl, load_lvl;
   logic [1:0] temp_lvl;
   int         n_mismatch = 0;
   int         n_tests = 0;

   cell_protection_state_controller #(.TICK_CYCLES(TK)) u_dut (.clk_sys_i, .rst_b_i,
      .opt_split_release_i, .opt_power_down_i, .opt_zero_inhibit_i, .cell_above_ovc_i,
      .cell_below_ovc_rel_i, .cell_below_ovd_i, .cell_at_ovd_rel_i, .cell_below_inhibit_i,
      .sense_ge_disch_oc_i, .sense_le_charge_oc_i, .load_ge_0p35_i, .load_below_0_i,
      .load_ge_0p7_i, .load_le_oc_rel_i, .temp_ge_detect_i, .temp_below_release_i,
      .charge_gate_on_o, .charge_gate_to_load_o, .discharge_gate_on_o, .monitor_gnd_res_on_o,
      .load_pullup_on_o, .load_pulldown_on_o, .power_down_o, .state_o);
   pack_side_model u_pack (.cell_lvl_i(cell_lvl), .load_lvl_i(load_lvl), .temp_lvl_i(temp_lvl),
      .above_ovc_o(cell_above_ovc_i), .below_ovc_rel_o(cell_below_ovc_rel_i),
      .below_ovd_o(cell_below_ovd_i), .at_ovd_rel_o(cell_at_ovd_rel_i),
      .below_inh_o(cell_below_inhibit_i), .ge_0p35_o(load_ge_0p35_i),
      .below_0_o(load_below_0_i), .ge_0p7_o(load_ge_0p7_i), .le_oc_rel_o(load_le_oc_rel_i),
      .hot_o(temp_ge_detect_i), .cool_o(temp_below_release_i));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // waits whole ticks and lands just after an edge, keeping the drive phase
   task automatic tk(input int n);
      repeat (n * TK) @(posedge clk_sys_i);
      #1;
   endtask : tk

   task automatic st(input logic [7:0] s, input logic c, input logic d);
      `CHK("state", s, state_o)
      `CHK("charge gate", c, charge_gate_on_o)
      `CHK("discharge gate", d, discharge_gate_on_o)
   endtask : st

   task automatic rst(input logic s, input logic p, input logic z);
      rst_b_i = 1'b0;
      {opt_split_release_i, opt_power_down_i, opt_zero_inhibit_i} = {s, p, z};
      {sense_ge_disch_oc_i, sense_le_charge_oc_i} = 2'h0;
      {cell_lvl, load_lvl, temp_lvl} = {3'h3, 3'h1, 2'h0};
      repeat (10) @(posedge clk_sys_i);
      #1;
      rst_b_i = 1'b1;
      tk(3);
   endtask : rst

   // a charger takes the block out of the attach state
   task automatic go_nrm;
      load_lvl = 3'h0;
      tk(4);
      load_lvl = 3'h1;
      tk(2);
   endtask : go_nrm

   task automatic ovd_in;
      cell_lvl = 3'h1;
      tk(OVD + 4);
   endtask : ovd_in

   task automatic ovc_in(input logic oc);
      cell_lvl = 3'h5;
      sense_ge_disch_oc_i = oc;
      tk(OVC + 4);
      sense_ge_disch_oc_i = 1'b0;
      st(8'h04, 1'b0, 1'b1);
   endtask : ovc_in

   task automatic t_attach;
      rst(1'b0, 1'b0, 1'b0);
      st(8'h01, 1'b1, 1'b0);
      go_nrm();
      st(8'h02, 1'b1, 1'b1);
      `CHK("resistors", 3'h4, {monitor_gnd_res_on_o, load_pullup_on_o, load_pulldown_on_o})
   endtask : t_attach

   task automatic t_overdis;
      cell_lvl = 3'h1;
      tk(OVD - 20);
      cell_lvl = 3'h3;
      tk(3);
      cell_lvl = 3'h1;
      tk(OVD - 10);
      st(8'h02, 1'b1, 1'b1);
      tk(14);
      st(8'h08, 1'b1, 1'b0);
      `CHK("pull-up", 2'h2, {load_pullup_on_o, load_pulldown_on_o})
      cell_lvl = 3'h2;
      tk(4);
      st(8'h08, 1'b1, 1'b0);
      load_lvl = 3'h0;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      load_lvl = 3'h1;
      ovd_in();
      {cell_lvl, load_lvl} = {3'h3, 3'h2};
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      load_lvl = 3'h1;
   endtask : t_overdis

   task automatic t_pd;
      rst(1'b0, 1'b1, 1'b0);
      go_nrm();
      ovd_in();
      load_lvl = 3'h3;
      tk(4);
      `CHK("power-down", 1'b1, power_down_o)
      cell_lvl = 3'h3;
      tk(4);
      `CHK("power-down", 1'b1, power_down_o)
      load_lvl = 3'h2;
      tk(6);
      `CHK("power-down", 1'b0, power_down_o)
      st(8'h02, 1'b1, 1'b1);
      rst(1'b0, 1'b0, 1'b0);
      go_nrm();
      ovd_in();
      load_lvl = 3'h3;
      tk(4);
      `CHK("power-down", 1'b0, power_down_o)
      cell_lvl = 3'h3;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      load_lvl = 3'h1;
   endtask : t_pd

   task automatic t_ovc;
      rst(1'b1, 1'b0, 1'b0);
      go_nrm();
      ovc_in(1'b1);
      cell_lvl = 3'h4;
      tk(4);
      st(8'h04, 1'b0, 1'b1);
      cell_lvl = 3'h3;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      ovc_in(1'b0);
      {cell_lvl, load_lvl} = {3'h4, 3'h2};
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      rst(1'b0, 1'b0, 1'b0);
      go_nrm();
      ovc_in(1'b0);
      {cell_lvl, load_lvl} = {3'h3, 3'h0};
      tk(4);
      st(8'h04, 1'b0, 1'b1);
      load_lvl = 3'h2;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      load_lvl = 3'h1;
   endtask : t_ovc

   task automatic t_oc;
      // a connected load holds the pin at supply, else the fault state releases at once
      {sense_ge_disch_oc_i, load_lvl} = {1'b1, 3'h4};
      tk(40);
      st(8'h20, 1'b1, 1'b0);
      {sense_ge_disch_oc_i, load_lvl} = {1'b0, 3'h4};
      tk(4);
      st(8'h20, 1'b1, 1'b0);
      load_lvl = 3'h1;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      sense_le_charge_oc_i = 1'b1;
      tk(40);
      sense_le_charge_oc_i = 1'b0;
      tk(4);
      st(8'h40, 1'b0, 1'b1);
      load_lvl = 3'h2;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
      load_lvl = 3'h1;
   endtask : t_oc

   task automatic t_heat;
      temp_lvl = 2'h2;
      tk(OHT - 20);
      st(8'h02, 1'b1, 1'b1);
      tk(24);
      st(8'h80, 1'b0, 1'b0);
      temp_lvl = 2'h1;
      tk(4);
      st(8'h80, 1'b0, 1'b0);
      temp_lvl = 2'h0;
      tk(4);
      st(8'h02, 1'b1, 1'b1);
   endtask : t_heat

   task automatic t_inhibit;
      rst(1'b0, 1'b0, 1'b1);
      cell_lvl = 3'h0;
      tk(3);
      `CHK("to load", 2'h1, {charge_gate_on_o, charge_gate_to_load_o})
      cell_lvl = 3'h3;
      tk(3);
      `CHK("to load", 1'b0, charge_gate_to_load_o)
   endtask : t_inhibit

   initial
   begin
      t_attach();
      t_overdis();
      t_oc();
      t_heat();
      t_pd();
      t_ovc();
      t_inhibit();
      wrap_up();
   end

   // the run needs about 75000 clocks; a hang is cut off well past that
   initial
   begin
      repeat (95000) @(posedge clk_sys_i);
      n_mismatch++;
      wrap_up();
   end
endmodule : test_cell_protection_state_controller
